// ### rtl/swsc_top.sv
// Purpose: standby entry, wake-up and STOP control with register access
// Assumes: core and interrupt controller share clk_in; pins are async
// Notes: the oscillator stop is shown by osc_enable_out
`timescale 1ns/1ns
`default_nettype none
`include "swsc_regs.svh"
module swsc_top #(
  parameter int unsigned WARM_CYC_SHORT = `SWSC_WARM_SHORT,
  parameter int unsigned WARM_CYC_MID = `SWSC_WARM_MID,
  parameter int unsigned WARM_CYC_LONG = `SWSC_WARM_LONG
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // register bus
  input wire swsc_pkg::swsc_axil_req_t axil_req_in,
  output swsc_pkg::swsc_axil_rsp_t axil_rsp_out,
  // core standby requests and mask level
  input wire logic halt_request_in,
  input wire logic doze_request_in,
  input wire logic [2:0] interrupt_mask_level_in,
  // interrupt controller request
  input wire logic intc_request_valid_in,
  input wire logic [2:0] intc_request_level_in,
  // wake-up pins, asynchronous
  input wire logic nmi_pin_in,
  input wire logic [`SWSC_EXT_N-1:0] external_interrupt_pins_in,
  input wire logic [`SWSC_KEY_N-1:0] key_wakeup_inputs_in,
  // on-chip interrupts
  input wire logic watchdog_interrupt_in,
  input wire logic [`SWSC_TMRB_N-1:0] timer_b_interrupts_in,
  input wire logic [`SWSC_TMRA_N-1:0] timer_a_interrupts_in,
  input wire logic [`SWSC_SER_N-1:0] serial_interrupts_in,
  input wire logic two_wire_interrupt_in,
  input wire logic [`SWSC_CONV_N-1:0] converter_interrupts_in,
  // clock control
  output logic cpu_clock_enable_out,
  output logic osc_enable_out,
  output logic sys_clock_enable_out,
  output logic slow_mode_out,
  output logic doze_active_out,
  output logic standby_active_out,
  // resume to core
  output logic resume_isr_out,
  output logic resume_retry_out,
  // pin gating
  output logic pin_input_gate_enable_out,
  output logic pin_output_hiz_out,
  output logic wake_pin_gate_enable_out
);
  localparam int DW = `SWSC_DATA_W;
  localparam int CTW = $bits(swsc_pkg::swsc_ctrl_t);
  localparam int STW = $bits(swsc_pkg::swsc_status_t);
  localparam int WSW = $bits(swsc_pkg::swsc_wsrc_t);

  swsc_pkg::swsc_core_state_t st_ff;
  swsc_pkg::swsc_core_state_t nxt_st;
  swsc_pkg::swsc_status_t status;
  swsc_pkg::swsc_wsrc_t wake_now;

  // register bus side
  logic wr_en;
  logic [`SWSC_ADDR_W-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [`SWSC_ADDR_W-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic rd_ok;
  logic [DW-1:0] ctrl_word;
  logic [DW-1:0] wdis_word;
  logic [DW-1:0] stat_word;
  logic [DW-1:0] wsrc_word;
  logic [DW-1:0] ctrl_merged;
  logic [DW-1:0] wdis_merged;

  // wake and warm-up
  logic onchip_irq;
  logic stop_wake;
  logic idle_wake;
  logic take_isr;
  logic stop_like;
  logic warm_clear;
  logic warm_run;
  logic warm_done;
  logic warm_short;

  function automatic logic [DW-1:0] merge_bytes(
    input logic [DW-1:0] old_v,
    input logic [DW-1:0] new_v,
    input logic [3:0] strb
  );
    logic [DW-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  swsc_axil u_axil (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .bus_in(axil_req_in),
    .bus_out(axil_rsp_out),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  swsc_warmup #(
    .CYC_SHORT(WARM_CYC_SHORT),
    .CYC_MID(WARM_CYC_MID),
    .CYC_LONG(WARM_CYC_LONG)
  ) u_warmup (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .clear_in(warm_clear),
    .run_in(warm_run),
    .sel_in(st_ff.ctrl.warmup_time_select),
    .done_out(warm_done),
    .too_short_out(warm_short)
  );

  // status view
  assign status = '{nmi_pending: st_ff.nmi_seen,
                    slow_active: st_ff.ctrl.slow_mode,
                    warmup_short: warm_short,
                    last_retry: st_ff.last_retry,
                    last_isr: st_ff.last_isr,
                    doze: st_ff.doze,
                    state: st_ff.state};

  // register words and read decode
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTW-1:0] = st_ff.ctrl;
    wdis_word = '0;
    wdis_word[`SWSC_WDIS_EXT_LO +: `SWSC_EXT_N] = st_ff.ext_wake_dis;
    wdis_word[`SWSC_WDIS_KEY_BIT] = st_ff.key_wake_dis;
    stat_word = '0;
    stat_word[STW-1:0] = status;
    wsrc_word = '0;
    wsrc_word[WSW-1:0] = st_ff.wake_src;
    rd_ok = 1'b1;
    unique case (rd_addr)
      `SWSC_OFS_CTRL: rd_data = ctrl_word;
      `SWSC_OFS_STATUS: rd_data = stat_word;
      `SWSC_OFS_WAKE_DIS: rd_data = wdis_word;
      `SWSC_OFS_WAKE_SRC: rd_data = wsrc_word;
      default: begin
        rd_data = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign wr_ok = (wr_addr == `SWSC_OFS_CTRL) ||
                 (wr_addr == `SWSC_OFS_STATUS) ||
                 (wr_addr == `SWSC_OFS_WAKE_DIS) ||
                 (wr_addr == `SWSC_OFS_WAKE_SRC);
  assign ctrl_merged = merge_bytes(ctrl_word, wr_data, wr_strb);
  assign wdis_merged = merge_bytes(wdis_word, wr_data, wr_strb);

  // wake sources, pins seen only after two flops
  assign onchip_irq = watchdog_interrupt_in |
                      (|timer_b_interrupts_in) |
                      (|timer_a_interrupts_in) |
                      (|serial_interrupts_in) |
                      two_wire_interrupt_in |
                      (|converter_interrupts_in);
  assign wake_now = '{onchip: onchip_irq,
                      key: |st_ff.key_sync,
                      ext: |st_ff.ext_sync,
                      nmi: st_ff.nmi_sync};
  assign idle_wake = wake_now.nmi | wake_now.ext | wake_now.key |
                     wake_now.onchip;
  // on-chip sources cannot end STOP, their clocks are off
  assign stop_wake = st_ff.nmi_sync |
                     (|(st_ff.ext_sync & ~st_ff.ext_wake_dis)) |
                     ((|st_ff.key_sync) & !st_ff.key_wake_dis);

  // where the core picks up after the wake
  assign take_isr = st_ff.nmi_seen | st_ff.nmi_sync |
                    (intc_request_valid_in &&
                     (intc_request_level_in >
                      interrupt_mask_level_in));

  // warm-up counter control
  assign warm_clear = (nxt_st.state == swsc_pkg::st_stop) &&
                      (st_ff.state != swsc_pkg::st_stop);
  assign warm_run = (st_ff.state == swsc_pkg::st_warm);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.nmi_meta = nmi_pin_in;
    nxt_st.nmi_sync = st_ff.nmi_meta;
    nxt_st.ext_meta = external_interrupt_pins_in;
    nxt_st.ext_sync = st_ff.ext_meta;
    nxt_st.key_meta = key_wakeup_inputs_in;
    nxt_st.key_sync = st_ff.key_meta;
    nxt_st.resume_isr = 1'b0;
    nxt_st.resume_retry = 1'b0;

    // software writes, status and wake source are read-only
    if (wr_en && (wr_addr == `SWSC_OFS_CTRL)) begin
      nxt_st.ctrl = swsc_pkg::swsc_ctrl_t'(ctrl_merged[CTW-1:0]);
    end
    if (wr_en && (wr_addr == `SWSC_OFS_WAKE_DIS)) begin
      nxt_st.ext_wake_dis =
        wdis_merged[`SWSC_WDIS_EXT_LO +: `SWSC_EXT_N];
      nxt_st.key_wake_dis = wdis_merged[`SWSC_WDIS_KEY_BIT];
    end

    unique case (st_ff.state)
      swsc_pkg::st_run: begin
        if (doze_request_in) begin
          nxt_st.state = swsc_pkg::st_idle;
          nxt_st.doze = 1'b1;
        end else if (halt_request_in) begin
          nxt_st.doze = 1'b0;
          if (st_ff.ctrl.standby_mode_select == `SWSC_STBY_STOP) begin
            nxt_st.state = swsc_pkg::st_stop;
            nxt_st.saved_slow = st_ff.ctrl.slow_mode;
          end else begin
            nxt_st.state = swsc_pkg::st_idle;
          end
        end
      end
      swsc_pkg::st_idle: begin
        if (idle_wake) begin
          // ctrl and wake-disable held across standby; doze and nmi_seen cleared
          nxt_st.state = swsc_pkg::st_run;
          nxt_st.doze = 1'b0;
          nxt_st.wake_src = wake_now;
          nxt_st.nmi_seen = 1'b0;
          nxt_st.resume_isr = take_isr;
          nxt_st.resume_retry = !take_isr;
          nxt_st.last_isr = take_isr;
          nxt_st.last_retry = !take_isr;
        end
      end
      swsc_pkg::st_stop: begin
        if (stop_wake) begin
          nxt_st.state = swsc_pkg::st_warm;
          nxt_st.nmi_seen = st_ff.nmi_sync;
          nxt_st.wake_src = '{onchip: 1'b0,
                              key: (|st_ff.key_sync) & !st_ff.key_wake_dis,
                              ext: |(st_ff.ext_sync & ~st_ff.ext_wake_dis),
                              nmi: st_ff.nmi_sync};
        end
      end
      swsc_pkg::st_warm: begin
        if (warm_done) begin
          nxt_st.state = swsc_pkg::st_run;
          nxt_st.ctrl.slow_mode = st_ff.saved_slow;
          nxt_st.nmi_seen = 1'b0;
          nxt_st.resume_isr = take_isr;
          nxt_st.resume_retry = !take_isr;
          nxt_st.last_isr = take_isr;
          nxt_st.last_retry = !take_isr;
        end
      end
    endcase
  end

  // reset ends any standby and clears all state; no RAM clear here
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // clock control
  assign stop_like = (st_ff.state == swsc_pkg::st_stop) ||
                     (st_ff.state == swsc_pkg::st_warm);
  assign cpu_clock_enable_out = (st_ff.state == swsc_pkg::st_run);
  assign osc_enable_out = (st_ff.state != swsc_pkg::st_stop);
  assign sys_clock_enable_out = !stop_like;
  assign slow_mode_out = st_ff.ctrl.slow_mode;
  assign doze_active_out = st_ff.doze;
  assign standby_active_out = (st_ff.state != swsc_pkg::st_run);

  // resume pulses, one cycle; a retry leaves the request pending
  assign resume_isr_out = st_ff.resume_isr;
  assign resume_retry_out = st_ff.resume_retry;

  // pin gating while the oscillator is stopped or warming
  assign pin_input_gate_enable_out = !stop_like ||
    st_ff.ctrl.stop_pin_drive_enable;
  assign pin_output_hiz_out = stop_like &&
    !st_ff.ctrl.stop_pin_drive_enable;
  assign wake_pin_gate_enable_out = 1'b1;
endmodule
`default_nettype wire

// ### rtl/swsc_regs.svh
// Purpose: offsets, field positions, codes and counts of the standby block
// Assumes: included by bare name; byte addresses on the register bus
// Notes: every register resets to zero except the STATUS warmup_short bit
`ifndef SWSC_REGS_SVH
`define SWSC_REGS_SVH

// register byte offsets
`define SWSC_OFS_CTRL 8'h00
`define SWSC_OFS_STATUS 8'h04
`define SWSC_OFS_WAKE_DIS 8'h08
`define SWSC_OFS_WAKE_SRC 8'h0c
`define SWSC_ADDR_W 8
`define SWSC_DATA_W 32

// wake-disable word layout
`define SWSC_WDIS_EXT_LO 0
`define SWSC_WDIS_KEY_BIT 16

// source counts
`define SWSC_EXT_N 11
`define SWSC_KEY_N 14
`define SWSC_TMRA_N 14
`define SWSC_TMRB_N 4
`define SWSC_SER_N 14
`define SWSC_CONV_N 3

// standby select code for STOP, any other code gives IDLE
`define SWSC_STBY_STOP 2'h1

// warm-up select codes
`define SWSC_WUPT_SHORT 2'h1
`define SWSC_WUPT_MID 2'h2
`define SWSC_WUPT_LONG 2'h3

// warm-up lengths in oscillator cycles
`define SWSC_WARM_SHORT 256
`define SWSC_WARM_MID 16384
`define SWSC_WARM_LONG 65536
`define SWSC_WARM_CNT_W 17

// least time the system needs to resume
`define SWSC_CLK_PERIOD_NS 50
`define SWSC_RESUME_MIN_NS 150000
`define SWSC_RESUME_MIN_CYC \
  ((`SWSC_RESUME_MIN_NS + `SWSC_CLK_PERIOD_NS - 1) / `SWSC_CLK_PERIOD_NS)

// bus responses
`define SWSC_RESP_OKAY 2'h0
`define SWSC_RESP_SLVERR 2'h2

`endif

// ### rtl/swsc_pkg.sv
// Purpose: types shared by the standby control modules
// Assumes: constants come from swsc_regs.svh
// Notes: all state of each module is one packed struct
`default_nettype none
`include "swsc_regs.svh"
package swsc_pkg;

  typedef enum logic [1:0] {st_run, st_idle, st_stop, st_warm} swsc_state_t;

  typedef struct packed {
    logic slow_mode;
    logic stop_pin_drive_enable;
    logic [1:0] warmup_time_select;
    logic [1:0] standby_mode_select;
  } swsc_ctrl_t;

  typedef struct packed {
    logic onchip;
    logic key;
    logic ext;
    logic nmi;
  } swsc_wsrc_t;

  typedef struct packed {
    logic nmi_pending;
    logic slow_active;
    logic warmup_short;
    logic last_retry;
    logic last_isr;
    logic doze;
    swsc_state_t state;
  } swsc_status_t;

  typedef struct packed {
    logic awvalid;
    logic [`SWSC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`SWSC_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`SWSC_ADDR_W-1:0] araddr;
    logic rready;
  } swsc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`SWSC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } swsc_axil_rsp_t;

  typedef struct packed {
    logic aw_held;
    logic [`SWSC_ADDR_W-1:0] awaddr;
    logic w_held;
    logic [`SWSC_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [`SWSC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } swsc_axil_state_t;

  typedef struct packed {
    logic [`SWSC_WARM_CNT_W-1:0] cnt;
  } swsc_warm_state_t;

  typedef struct packed {
    logic nmi_meta;
    logic nmi_sync;
    logic [`SWSC_EXT_N-1:0] ext_meta;
    logic [`SWSC_EXT_N-1:0] ext_sync;
    logic [`SWSC_KEY_N-1:0] key_meta;
    logic [`SWSC_KEY_N-1:0] key_sync;
    swsc_state_t state;
    logic doze;
    swsc_ctrl_t ctrl;
    logic [`SWSC_EXT_N-1:0] ext_wake_dis;
    logic key_wake_dis;
    logic saved_slow;
    logic nmi_seen;
    swsc_wsrc_t wake_src;
    logic resume_isr;
    logic resume_retry;
    logic last_isr;
    logic last_retry;
  } swsc_core_state_t;

endpackage
`default_nettype wire

// ### rtl/swsc_axil.sv
// Purpose: AXI4-Lite slave front end for the standby registers
// Assumes: register file answers combinationally on address
// Notes: one write and one read in flight; unmapped gives SLVERR
`timescale 1ns/1ns
`default_nettype none
`include "swsc_regs.svh"
module swsc_axil (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // bus
  input wire swsc_pkg::swsc_axil_req_t bus_in,
  output swsc_pkg::swsc_axil_rsp_t bus_out,
  // register file side
  output logic wr_en_out,
  output logic [`SWSC_ADDR_W-1:0] wr_addr_out,
  output logic [`SWSC_DATA_W-1:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [`SWSC_ADDR_W-1:0] rd_addr_out,
  input wire logic [`SWSC_DATA_W-1:0] rd_data_in,
  input wire logic rd_ok_in
);
  swsc_pkg::swsc_axil_state_t st_ff;
  swsc_pkg::swsc_axil_state_t nxt_st;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;

  assign aw_rdy = !st_ff.aw_held && !st_ff.bvalid;
  assign w_rdy = !st_ff.w_held && !st_ff.bvalid;
  assign ar_rdy = !st_ff.rvalid;
  assign wr_en_out = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign wr_addr_out = st_ff.awaddr;
  assign wr_data_out = st_ff.wdata;
  assign wr_strb_out = st_ff.wstrb;
  assign rd_addr_out = bus_in.araddr;
  assign bus_out = '{awready: aw_rdy, wready: w_rdy, bvalid: st_ff.bvalid,
                     bresp: st_ff.bresp, arready: ar_rdy,
                     rvalid: st_ff.rvalid, rdata: st_ff.rdata,
                     rresp: st_ff.rresp};

  always_comb begin
    nxt_st = st_ff;
    if (bus_in.awvalid && aw_rdy) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = bus_in.awaddr;
    end
    if (bus_in.wvalid && w_rdy) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = bus_in.wdata;
      nxt_st.wstrb = bus_in.wstrb;
    end
    if (wr_en_out) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_ok_in ? `SWSC_RESP_OKAY : `SWSC_RESP_SLVERR;
    end
    if (st_ff.bvalid && bus_in.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (bus_in.arvalid && ar_rdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_data_in;
      nxt_st.rresp = rd_ok_in ? `SWSC_RESP_OKAY : `SWSC_RESP_SLVERR;
    end else if (st_ff.rvalid && bus_in.rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ### rtl/swsc_warmup.sv
// Purpose: oscillator warm-up counter for leaving STOP
// Assumes: clocked by the restarted oscillator
// Notes: done is high in the last counted cycle
`timescale 1ns/1ns
`default_nettype none
`include "swsc_regs.svh"
module swsc_warmup #(
  parameter int unsigned CYC_SHORT = `SWSC_WARM_SHORT,
  parameter int unsigned CYC_MID = `SWSC_WARM_MID,
  parameter int unsigned CYC_LONG = `SWSC_WARM_LONG
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // control
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [1:0] sel_in,
  // status
  output logic done_out,
  output logic too_short_out
);
  localparam int CW = `SWSC_WARM_CNT_W;
  swsc_pkg::swsc_warm_state_t st_ff;
  swsc_pkg::swsc_warm_state_t nxt_st;
  logic [CW-1:0] target;

  always_comb begin
    unique case (sel_in)
      `SWSC_WUPT_MID: target = CW'(CYC_MID);
      `SWSC_WUPT_LONG: target = CW'(CYC_LONG);
      default: target = CW'(CYC_SHORT);
    endcase
  end

  assign done_out = run_in && (st_ff.cnt == (target - CW'(1)));
  assign too_short_out = target < CW'(`SWSC_RESUME_MIN_CYC);

  always_comb begin
    nxt_st = st_ff;
    if (clear_in) begin
      nxt_st.cnt = '0;
    end else if (run_in && !done_out) begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ### testbench/swsc_intc_model.sv
// Purpose: interrupt controller stand-in holding one request
// Assumes: request loaded while raise is high
// Notes: level 0 means no request
`timescale 1ns/1ns
`default_nettype none
module swsc_intc_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // bench command and core resume
  input wire logic raise_in,
  input wire logic [2:0] level_in,
  input wire logic resume_isr_in,
  // request to block
  output logic valid_out,
  output logic [2:0] level_out
);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      valid_out <= 1'b0;
      level_out <= 3'h0;
    end else if (raise_in) begin
      valid_out <= level_in != 3'h0;
      level_out <= level_in;
    end else if (resume_isr_in) begin
      valid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/swsc_checker.sv
// Purpose: port checks of swsc_top
// Assumes: one clock, reset low
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module swsc_checker #(
  parameter int unsigned WARM_CYC_SHORT = 4,
  parameter int unsigned WARM_CYC_LONG = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // core and intc
  input wire logic doze_request_in,
  input wire logic [2:0] interrupt_mask_level_in,
  input wire logic intc_request_valid_in,
  input wire logic [2:0] intc_request_level_in,
  // outputs
  input wire logic cpu_clock_enable_out,
  input wire logic osc_enable_out,
  input wire logic sys_clock_enable_out,
  input wire logic doze_active_out,
  input wire logic standby_active_out,
  input wire logic resume_isr_out,
  input wire logic resume_retry_out,
  input wire logic pin_input_gate_enable_out,
  input wire logic pin_output_hiz_out,
  input wire logic wake_pin_gate_enable_out
);
  logic unmask_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      unmask_ff <= 1'b0;
    end else begin
      unmask_ff <= intc_request_valid_in &&
        (intc_request_level_in > interrupt_mask_level_in);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_doze;
    doze_request_in && cpu_clock_enable_out |=>
      doze_active_out && osc_enable_out;
  endproperty
  a_doze: assert property (p_doze) else $error("doze entry wrong");
  property p_rst;
    $rose(rst_b_in) |-> cpu_clock_enable_out && !standby_active_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset exit wrong");
  property p_stop;
    !osc_enable_out |-> !sys_clock_enable_out && !cpu_clock_enable_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not halted");
  property p_pins;
    !osc_enable_out |-> pin_output_hiz_out != pin_input_gate_enable_out;
  endproperty
  a_pins: assert property (p_pins) else $error("pin state wrong");
  property p_wgate;
    wake_pin_gate_enable_out;
  endproperty
  a_wgate: assert property (p_wgate) else $error("wake gate off");
  property p_warm;
    $rose(osc_enable_out) |-> !sys_clock_enable_out ##0
      ##[WARM_CYC_SHORT:WARM_CYC_LONG] $rose(sys_clock_enable_out);
  endproperty
  a_warm: assert property (p_warm) else $error("warm-up length");
  property p_retry;
    resume_retry_out |-> !unmask_ff;
  endproperty
  a_retry: assert property (p_retry) else $error("retry unmasked");
  property p_pulse;
    resume_isr_out |-> !resume_retry_out ##1 !resume_isr_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("resume pulse");
  c_warm: cover property ($rose(osc_enable_out));
  c_isr: cover property (resume_isr_out);
  c_retry: cover property (resume_retry_out);
endmodule
bind swsc_top swsc_checker #(
  .WARM_CYC_SHORT(WARM_CYC_SHORT),
  .WARM_CYC_LONG(WARM_CYC_LONG)
) u_chk (
  .clk_in, .rst_b_in, .doze_request_in, .interrupt_mask_level_in,
  .intc_request_valid_in, .intc_request_level_in, .cpu_clock_enable_out,
  .osc_enable_out, .sys_clock_enable_out, .doze_active_out,
  .standby_active_out, .resume_isr_out, .resume_retry_out,
  .pin_input_gate_enable_out, .pin_output_hiz_out, .wake_pin_gate_enable_out
);
`default_nettype wire

// ### testbench/tb_standby_wakeup_stop_control.sv
// Purpose: self-checking bench of swsc_top
// Assumes: short warm-up counts 4/8/16
// Notes: random seed fixed
`timescale 1ns/1ns
`default_nettype none
module tb_standby_wakeup_stop_control;
  logic clk_in = 0, rst_b_in = 0, halt = 0, doze = 0, nmi = 0, raise = 0;
  logic [2:0] mask = 0, ilvl = 0, lvl, m, ic_lvl;
  logic [10:0] ext = 0;
  logic [13:0] key = 0;
  logic [36:0] oc = 0;
  logic [1:0] sel, resp;
  logic [31:0] rd;
  logic ic_v, cpu, osc, sys, slow, dz, stby, isr, rty, gate, hiz, wg, s, dv;
  swsc_pkg::swsc_axil_req_t req = '0;
  swsc_pkg::swsc_axil_rsp_t rsp;
  int n_errors = 0, n_checks = 0, n;
  always #25 clk_in = ~clk_in;
  swsc_top #(.WARM_CYC_SHORT(4), .WARM_CYC_MID(8), .WARM_CYC_LONG(16)) dut (
    .clk_in, .rst_b_in, .axil_req_in(req), .axil_rsp_out(rsp),
    .halt_request_in(halt), .doze_request_in(doze),
    .interrupt_mask_level_in(mask), .intc_request_valid_in(ic_v),
    .intc_request_level_in(ic_lvl), .nmi_pin_in(nmi),
    .external_interrupt_pins_in(ext), .key_wakeup_inputs_in(key),
    .watchdog_interrupt_in(oc[36]), .timer_b_interrupts_in(oc[35:32]),
    .timer_a_interrupts_in(oc[31:18]), .serial_interrupts_in(oc[17:4]),
    .two_wire_interrupt_in(oc[3]), .converter_interrupts_in(oc[2:0]),
    .cpu_clock_enable_out(cpu), .osc_enable_out(osc),
    .sys_clock_enable_out(sys), .slow_mode_out(slow),
    .doze_active_out(dz), .standby_active_out(stby),
    .resume_isr_out(isr), .resume_retry_out(rty),
    .pin_input_gate_enable_out(gate), .pin_output_hiz_out(hiz),
    .wake_pin_gate_enable_out(wg)
  );
  swsc_intc_model u_intc (
    .clk_in, .rst_b_in, .raise_in(raise), .level_in(ilvl),
    .resume_isr_in(isr), .valid_out(ic_v), .level_out(ic_lvl)
  );
  function automatic int warm(input int c);
    return (c == 1) ? 4 : (c == 2) ? 8 : 16;
  endfunction
  function automatic logic exp_isr(input logic [2:0] l, input logic [2:0] k);
    return l > k;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= {1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    do begin
      @(posedge clk_in);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_in);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic irq(input logic [2:0] l);
    @(posedge clk_in);
    raise <= 1'b1;
    ilvl <= l;
    @(posedge clk_in);
    raise <= 1'b0;
  endtask
  task automatic enter(input logic d);
    @(posedge clk_in);
    doze <= d;
    halt <= !d;
    @(posedge clk_in);
    doze <= 1'b0;
    halt <= 1'b0;
    #1;
  endtask
  task automatic wexit;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (!(isr | rty));
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report;
  end
  initial begin
    void'($urandom(32'h5a9d));
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rdr(8'h04);
    chk("status", 32'h20, rd);
    rdr(8'h10);
    chk("resp", 32'h2, resp);
    $display("test regs done");
    for (int i = 0; i < 6; i++) begin
      lvl = 3'($urandom);
      m = (i < 2) ? lvl : 3'($urandom);
      sel = i[0] ? 2'h1 : (i == 2) ? 2'h3 : 2'h0;
      wr(8'h00, {30'h0, sel});
      @(posedge clk_in);
      mask <= m;
      enter(i[0]);
      chk("doze", i[0], dz);
      chk("osc", 32'h1, osc);
      irq(lvl);
      oc <= 37'h1 << ($urandom % 37);
      wexit;
      chk("isr", exp_isr(lvl, m), isr);
      oc <= '0;
      irq(3'h0);
      rdr(8'h00);
      chk("keep", {30'h0, sel}, rd);
    end
    $display("test idle done");
    for (int c = 1; c < 4; c++) begin
      s = 1'($urandom);
      dv = 1'($urandom);
      sel = (c == 1) ? 2'h3 : 2'(c);
      wr(8'h00, {26'h0, s, dv, sel, 2'h1});
      enter(1'b0);
      chk("osc", 32'h0, osc);
      chk("hiz", !dv, hiz);
      chk("gate", dv, gate);
      chk("wgate", 32'h1, wg);
      @(posedge clk_in);
      oc <= '1;
      repeat (6) @(posedge clk_in);
      oc <= '0;
      chk("stay", 32'h0, osc);
      mask <= 3'h7;
      nmi <= c == 1;
      ext <= (c == 2) ? 11'h1 << ($urandom % 11) : 11'h0;
      key <= (c == 3) ? 14'h1 << ($urandom % 14) : 14'h0;
      do begin
        @(posedge clk_in);
        #1;
      end while (!osc);
      wexit;
      chk("warm", warm(sel), n);
      chk("sys", 32'h1, sys);
      chk("isr", c == 1, isr);
      chk("slow", s, slow);
      @(posedge clk_in);
      nmi <= 1'b0;
      ext <= '0;
      key <= '0;
    end
    $display("test stop done");
    wr(8'h00, 32'h3d);
    enter(1'b0);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("stby", 32'h0, stby);
    rdr(8'h00);
    chk("ctrl", 32'h0, rd);
    $display("test reset done");
    final_report;
  end
endmodule
`default_nettype wire
